// ==== dv/sso_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module sso_master (
    input wire logic clock,
    output sso_pkg::sso_od_req_s od_req,
    input wire sso_pkg::sso_od_rsp_s od_rsp
);
    import sso_pkg::*;

    // lateral preset limit in one-degree units
    localparam logic [15:0] LAT_PRESET_MAX = 16'h0050;

    initial od_req = '0;

    ////////////////////////////////////////////////////////////////////////
    // degrees from a lateral readout, scaled by the selected resolution
    function automatic int lat_degrees(input logic [15:0] v, input logic [15:0] res);
        return $signed(v) * int'(res);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one dictionary access: request pulse on one taking edge, answer a cycle later
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        rd = 16'h0000;
        err = 1'b1;
        if (w && (idx == SSO_IDX_LAT_PRESET || idx == SSO_IDX_PRESET_Y) && $signed(wd) > $signed(LAT_PRESET_MAX)) begin
            wd = LAT_PRESET_MAX;
        end
        @(negedge clock);
        // signed 16-bit word; lateral presets above LAT_PRESET_MAX go out clamped to it
        od_req <= '{wr: w, rd: !w, index: idx, wdata: wd};
        for (n = 0; n < 4 && !ok; n++) begin
            @(negedge clock);
            // released bus shows inverted leftovers, not the last value
            od_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~wd};
            if (od_rsp.ack === 1'b1) begin
                ok = 1'b1;
                rd = od_rsp.rdata;
                err = od_rsp.err;
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sso_pkg::*;

    typedef struct packed {
        logic [1:0] op;
        logic [15:0] x;
        logic [15:0] exp_l;
        logic [15:0] exp_t;
    } sso_row_s;

    logic clock;
    logic nrst;
    logic ce;
    sso_sample_s raw_in;
    sso_od_req_s od_req;
    sso_od_rsp_s od_rsp;
    sso_sample_s slope_out;
    sso_word_t resolution;
    int err_total;
    int num_checks;
    int cycles;
    logic [15:0] rd;
    logic er;
    logic ok;

    // op bits, raw reading, expected outputs; prime 0005/0105, preset 0010, diff 0003
    sso_row_s rows [6] = '{
        '{2'h0, 16'h1234, 16'h1234, 16'h1334},
        '{2'h1, 16'h1234, 16'hEDCC, 16'hECCC},
        '{2'h2, 16'h1234, 16'h1242, 16'h1242},
        '{2'h3, 16'h1234, 16'hEDE4, 16'hEDE4},
        '{2'h1, 16'h0000, 16'h0000, 16'hFF00},
        '{2'h3, 16'h8000, 16'h8018, 16'h8018}
    };
    logic [15:0] rst_idx [7] = '{16'h6011, 16'h6012, 16'h6013, 16'h6014, 16'h6021, 16'h6022, 16'h6000};
    logic [15:0] rst_exp [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h03E8};
    logic [15:0] res_code [3] = '{16'h0064, 16'h000A, 16'h03E8};

    sso_unit uut (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .raw_in(raw_in),
        .od_req(od_req),
        .od_rsp(od_rsp),
        .slope_out(slope_out),
        .resolution(resolution)
    );

    sso_master m (
        .clock(clock),
        .od_req(od_req),
        .od_rsp(od_rsp)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial clock = 1'b0;
    always #4 clock = ~clock;

    initial cycles = 0;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic conclude;
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] idx, input logic [15:0] d);
        m.xfer(w, idx, d, rd, er, ok);
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t no answer at index %h", $time, idx);
        end
    endtask

    task automatic rdr(input logic [15:0] idx, input logic [15:0] exp);
        acc(1'b0, idx, 16'h0000);
        chk(rd, exp);
    endtask

    // one raw sample pair; returns in the cycle the result is shown
    task automatic smp(input logic [15:0] l, input logic [15:0] t);
        @(negedge clock);
        raw_in <= '{valid: 1'b1, longitudinal: l, lateral: t};
        @(negedge clock);
        raw_in <= '{valid: 1'b0, longitudinal: ~l, lateral: ~t};
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        raw_in = '0;
        err_total = 0;
        num_checks = 0;
        repeat (16) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        // table of operating modes on both axes
        foreach (rows[i]) begin
            acc(1'b1, SSO_IDX_LONG_OP, {14'h0000, rows[i].op});
            acc(1'b1, SSO_IDX_LAT_OP, {14'h0000, rows[i].op});
            acc(1'b1, SSO_IDX_LONG_DIFF, 16'h0003);
            acc(1'b1, SSO_IDX_LAT_DIFF, 16'h0003);
            smp(16'h0005, 16'h0105);
            acc(1'b1, SSO_IDX_LONG_PRESET, 16'h0010);
            acc(1'b1, SSO_IDX_LAT_PRESET, 16'h0010);
            smp(rows[i].x, rows[i].x + 16'h0100);
            chk({15'h0000, slope_out.valid}, 16'h0001);
            chk(slope_out.longitudinal, rows[i].exp_l);
            chk(slope_out.lateral, rows[i].exp_t);
        end
        // derived and user offsets, both slopes and a refused slope write after the last row
        rdr(SSO_IDX_LONG_AUTO, 16'h0015);
        rdr(SSO_IDX_LONG_DIFF, 16'h0003);
        rdr(SSO_IDX_LAT_DIFF, 16'h0003);
        rdr(SSO_IDX_LONG_VALUE, 16'h8018);
        rdr(SSO_IDX_LAT_VALUE, 16'h8018);
        acc(1'b1, SSO_IDX_LAT_VALUE, 16'h1111);
        chk({15'h0000, er}, 16'h0001);
        rdr(SSO_IDX_LAT_VALUE, 16'h8018);
        // resolution codes, then a refused code
        foreach (res_code[i]) begin
            acc(1'b1, SSO_IDX_RESOLUTION, res_code[i]);
            chk(resolution, res_code[i]);
        end
        acc(1'b1, SSO_IDX_RESOLUTION, 16'h0005);
        chk({15'h0000, er}, 16'h0001);
        chk(resolution, 16'h03E8);
        // unmapped index answers with an error and zero data
        acc(1'b0, 16'h6030, 16'h0000);
        chk({15'h0000, er}, 16'h0001);
        chk(rd, 16'h0000);
        // a sample offered while frozen gives no result
        @(negedge clock);
        ce = 1'b0;
        smp(16'h0042, 16'h0042);
        chk({15'h0000, slope_out.valid}, 16'h0000);
        chk(slope_out.longitudinal, 16'h8018);
        ce = 1'b1;
        // second reset restores the register table
        @(negedge clock);
        nrst = 1'b0;
        @(negedge clock);
        nrst = 1'b1;
        foreach (rst_idx[i]) begin
            rdr(rst_idx[i], rst_exp[i]);
        end
        // alias preset writes recompute the automatic offset
        smp(16'h0005, 16'h0105);
        acc(1'b1, SSO_IDX_PRESET_X, 16'h0020);
        rdr(SSO_IDX_LONG_AUTO, 16'h001B);
        acc(1'b1, SSO_IDX_PRESET_Y, 16'h0020);
        rdr(SSO_IDX_LAT_AUTO, 16'hFF1B);
        acc(1'b1, SSO_IDX_LONG_AUTO, 16'h0007);
        rdr(SSO_IDX_LONG_AUTO, 16'h0007);
        acc(1'b1, SSO_IDX_LONG_PRESET32, 16'h0030);
        rdr(SSO_IDX_LONG_AUTO, 16'h002B);
        rdr(SSO_IDX_LONG_DIFF, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire

// ==== rtl/sso_axis.sv ====
`timescale 1ns/1ps
`default_nettype none
module sso_axis (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic sample_valid,
    input wire sso_pkg::sso_word_t raw,
    input wire logic [7:0] op,
    input wire logic preset_wr,
    input wire sso_pkg::sso_word_t preset_val,
    input wire logic auto_wr,
    input wire sso_pkg::sso_word_t auto_val,
    input wire sso_pkg::sso_word_t diff,
    output sso_pkg::sso_word_t auto_offset,
    output sso_pkg::sso_word_t slope_out
);
    import sso_pkg::*;

    sso_word_t raw_q, raw_d;
    sso_word_t auto_q, auto_d;
    sso_word_t out_q, out_d;
    sso_word_t inv_x;
    sso_word_t base;
    sso_word_t scaled;
    logic inv_en;
    logic scale_en;

    assign inv_en = op[SSO_OP_INV_BIT];
    assign scale_en = op[SSO_OP_SCALE_BIT];
    assign auto_offset = auto_q;
    assign slope_out = out_q;

    // next output sample and automatic offset
    always_comb begin
        inv_x = 16'(SSO_INV_MOD16 - {1'b0, raw});
        base = inv_en ? inv_x : raw;
        scaled = 16'(base + auto_q + diff);
        raw_d = raw_q;
        out_d = out_q;
        auto_d = auto_q;
        if (sample_valid) begin
            raw_d = raw;
            out_d = scale_en ? scaled : base;
        end
        if (preset_wr) begin
            auto_d = inv_en ? 16'(preset_val + raw_q) : 16'(preset_val - raw_q);
        end else if (auto_wr) begin
            auto_d = auto_val;
        end
    end

    // state registers, frozen while ce is low
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            raw_q <= SSO_PRESET_RST;
            auto_q <= SSO_AUTO_RST;
            out_q <= SSO_PRESET_RST;
        end else if (ce) begin
            raw_q <= raw_d;
            auto_q <= auto_d;
            out_q <= out_d;
        end
    end

    sequence s_take_plain;
        ce && sample_valid && !op[SSO_OP_INV_BIT] && !op[SSO_OP_SCALE_BIT];
    endsequence
    sequence s_preset_direct;
        ce && preset_wr && !op[SSO_OP_INV_BIT];
    endsequence
    sequence s_preset_inverted;
        ce && preset_wr && op[SSO_OP_INV_BIT];
    endsequence

    a_plain_pass: assert property (@(posedge clock) disable iff (!nrst)
        s_take_plain |=> out_q == $past(raw))
        else $error("plain sample not passed through");
    a_inv_output: assert property (@(posedge clock) disable iff (!nrst)
        ce && sample_valid && op[1:0] == 2'b01 |=> out_q == 16'(17'h10000 - {1'b0, $past(raw)}))
        else $error("inverted sample wrong");
    a_scale_output: assert property (@(posedge clock) disable iff (!nrst)
        ce && sample_valid && op[1:0] == 2'b10
        |=> out_q == 16'($past(raw) + $past(auto_q) + $past(diff)))
        else $error("scaled sample wrong");
    a_both_output: assert property (@(posedge clock) disable iff (!nrst)
        ce && sample_valid && op[1:0] == 2'b11
        |=> out_q == 16'(16'(17'h10000 - {1'b0, $past(raw)}) + $past(auto_q) + $past(diff)))
        else $error("inverted scaled sample wrong");
    a_auto_direct: assert property (@(posedge clock) disable iff (!nrst)
        s_preset_direct |=> auto_q == 16'($past(preset_val) - $past(raw_q)))
        else $error("automatic offset wrong");
    a_auto_inverted: assert property (@(posedge clock) disable iff (!nrst)
        s_preset_inverted |=> auto_q == 16'($past(preset_val) + $past(raw_q)))
        else $error("inverted automatic offset wrong");
endmodule
`default_nettype wire

// ==== rtl/sso_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module sso_decode (
    input wire logic [15:0] index,
    output sso_pkg::sso_sel_e sel
);
    import sso_pkg::*;

    // index to entry, preset aliases fold onto their axis
    always_comb begin
        case (index)
            SSO_IDX_RESOLUTION: sel = SSO_SEL_RES;
            SSO_IDX_LONG_VALUE: sel = SSO_SEL_LONG_VAL;
            SSO_IDX_LONG_OP: sel = SSO_SEL_LONG_OP;
            SSO_IDX_LONG_PRESET: sel = SSO_SEL_LONG_PRE;
            SSO_IDX_LONG_PRESET32: sel = SSO_SEL_LONG_PRE;
            SSO_IDX_PRESET_X: sel = SSO_SEL_LONG_PRE;
            SSO_IDX_LONG_AUTO: sel = SSO_SEL_LONG_AUTO;
            SSO_IDX_LONG_DIFF: sel = SSO_SEL_LONG_DIFF;
            SSO_IDX_LAT_VALUE: sel = SSO_SEL_LAT_VAL;
            SSO_IDX_LAT_OP: sel = SSO_SEL_LAT_OP;
            SSO_IDX_LAT_PRESET: sel = SSO_SEL_LAT_PRE;
            SSO_IDX_PRESET_Y: sel = SSO_SEL_LAT_PRE;
            SSO_IDX_LAT_AUTO: sel = SSO_SEL_LAT_AUTO;
            SSO_IDX_LAT_DIFF: sel = SSO_SEL_LAT_DIFF;
            default: sel = SSO_SEL_NONE;
        endcase
    end
endmodule
`default_nettype wire

// ==== rtl/sso_pkg.sv ====
`default_nettype none
package sso_pkg;
    // one dictionary word
    typedef logic [15:0] sso_word_t;

    // dictionary indices
    localparam logic [15:0] SSO_IDX_RESOLUTION = 16'h6000;
    localparam logic [15:0] SSO_IDX_LONG_VALUE = 16'h6010;
    localparam logic [15:0] SSO_IDX_LONG_OP = 16'h6011;
    localparam logic [15:0] SSO_IDX_LONG_PRESET = 16'h6012;
    localparam logic [15:0] SSO_IDX_LONG_AUTO = 16'h6013;
    localparam logic [15:0] SSO_IDX_LONG_DIFF = 16'h6014;
    localparam logic [15:0] SSO_IDX_LONG_PRESET32 = 16'h6112;
    localparam logic [15:0] SSO_IDX_PRESET_X = 16'h2600;
    localparam logic [15:0] SSO_IDX_LAT_VALUE = 16'h6020;
    localparam logic [15:0] SSO_IDX_LAT_OP = 16'h6021;
    localparam logic [15:0] SSO_IDX_LAT_PRESET = 16'h6022;
    localparam logic [15:0] SSO_IDX_LAT_AUTO = 16'h6023;
    localparam logic [15:0] SSO_IDX_LAT_DIFF = 16'h6024;
    localparam logic [15:0] SSO_IDX_PRESET_Y = 16'h2601;

    // operating parameter field positions
    localparam int unsigned SSO_OP_INV_BIT = 0;
    localparam int unsigned SSO_OP_SCALE_BIT = 1;

    // values after reset, and the resolution codes
    localparam logic [7:0] SSO_OP_RST = 8'h00;
    localparam logic [15:0] SSO_PRESET_RST = 16'h0000;
    localparam logic [15:0] SSO_AUTO_RST = 16'h0000;
    localparam logic [15:0] SSO_DIFF_RST = 16'h0000;
    localparam logic [15:0] SSO_RES_1DEG = 16'h03E8;
    localparam logic [15:0] SSO_RES_TENTH = 16'h0064;
    localparam logic [15:0] SSO_RES_HUNDREDTH = 16'h000A;
    localparam logic [15:0] SSO_RES_RST = SSO_RES_1DEG;

    // inversion modulus of a 16-bit entry
    localparam logic [16:0] SSO_INV_MOD16 = 17'h10000;

    // cycles from a taken request to its answer
    localparam int unsigned SSO_ANSWER_CYCLES = 1;

    // dictionary entry selected by an index
    typedef enum logic [3:0] {
        SSO_SEL_NONE = 4'h0,
        SSO_SEL_RES = 4'h1,
        SSO_SEL_LONG_VAL = 4'h2,
        SSO_SEL_LONG_OP = 4'h3,
        SSO_SEL_LONG_PRE = 4'h4,
        SSO_SEL_LONG_AUTO = 4'h5,
        SSO_SEL_LONG_DIFF = 4'h6,
        SSO_SEL_LAT_VAL = 4'h7,
        SSO_SEL_LAT_OP = 4'h8,
        SSO_SEL_LAT_PRE = 4'h9,
        SSO_SEL_LAT_AUTO = 4'hA,
        SSO_SEL_LAT_DIFF = 4'hB
    } sso_sel_e;

    // dictionary access request and answer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [15:0] wdata;
    } sso_od_req_s;

    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } sso_od_rsp_s;

    // raw or processed tilt sample pair
    typedef struct packed {
        logic valid;
        logic [15:0] longitudinal;
        logic [15:0] lateral;
    } sso_sample_s;
endpackage
`default_nettype wire

// ==== rtl/sso_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module sso_unit (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire sso_pkg::sso_sample_s raw_in,
    input wire sso_pkg::sso_od_req_s od_req,
    output sso_pkg::sso_od_rsp_s od_rsp,
    output sso_pkg::sso_sample_s slope_out,
    output sso_pkg::sso_word_t resolution
);
    import sso_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    sso_sel_e sel;

    logic [7:0] long_op_q, long_op_d;
    logic [7:0] lat_op_q, lat_op_d;
    sso_word_t long_preset_q, long_preset_d;
    sso_word_t lat_preset_q, lat_preset_d;
    sso_word_t long_diff_q, long_diff_d;
    sso_word_t lat_diff_q, lat_diff_d;
    sso_word_t res_q, res_d;
    sso_od_rsp_s rsp_q, rsp_d;
    logic valid_q, valid_d;

    logic long_pre_wr;
    logic lat_pre_wr;
    logic long_auto_wr;
    logic lat_auto_wr;
    logic res_ok;
    sso_word_t rd_word;

    sso_word_t long_auto;
    sso_word_t lat_auto;
    sso_word_t long_slope;
    sso_word_t lat_slope;

    // per-axis views for the axis loop
    logic [1:0] ax_pre_wr;
    logic [1:0] ax_auto_wr;
    logic [7:0] ax_op [2];
    sso_word_t ax_raw [2];
    sso_word_t ax_diff [2];
    sso_word_t ax_auto [2];
    sso_word_t ax_slope [2];

    ////////////////////////////////////////////////////////////////////////////
    // index decode

    sso_decode u_decode (
        .index(od_req.index),
        .sel(sel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // per-axis datapaths

    // axis 0 is longitudinal, axis 1 lateral
    assign ax_raw[0] = raw_in.longitudinal;
    assign ax_raw[1] = raw_in.lateral;
    assign ax_op[0] = long_op_q;
    assign ax_op[1] = lat_op_q;
    assign ax_pre_wr[0] = long_pre_wr;
    assign ax_pre_wr[1] = lat_pre_wr;
    assign ax_auto_wr[0] = long_auto_wr;
    assign ax_auto_wr[1] = lat_auto_wr;
    assign ax_diff[0] = long_diff_q;
    assign ax_diff[1] = lat_diff_q;

    // one datapath per axis, same arithmetic on its own settings
    generate
        for (genvar g = 0; g < 2; g++) begin : g_axis
            sso_axis u_axis (
                .clock(clock),
                .nrst(nrst),
                .ce(ce),
                .sample_valid(raw_in.valid),
                .raw(ax_raw[g]),
                .op(ax_op[g]),
                .preset_wr(ax_pre_wr[g]),
                .preset_val(od_req.wdata),
                .auto_wr(ax_auto_wr[g]),
                .auto_val(od_req.wdata),
                .diff(ax_diff[g]),
                .auto_offset(ax_auto[g]),
                .slope_out(ax_slope[g])
            );
        end
    endgenerate

    // axis results back under their own names
    assign long_auto = ax_auto[0];
    assign lat_auto = ax_auto[1];
    assign long_slope = ax_slope[0];
    assign lat_slope = ax_slope[1];

    ////////////////////////////////////////////////////////////////////////////
    // read data multiplexer

    // selected entry seen by a read
    always_comb begin
        case (sel)
            SSO_SEL_RES: rd_word = res_q;
            SSO_SEL_LONG_VAL: rd_word = long_slope;
            SSO_SEL_LONG_OP: rd_word = {8'h00, long_op_q};
            SSO_SEL_LONG_PRE: rd_word = long_preset_q;
            SSO_SEL_LONG_AUTO: rd_word = long_auto;
            SSO_SEL_LONG_DIFF: rd_word = long_diff_q;
            SSO_SEL_LAT_VAL: rd_word = lat_slope;
            SSO_SEL_LAT_OP: rd_word = {8'h00, lat_op_q};
            SSO_SEL_LAT_PRE: rd_word = lat_preset_q;
            SSO_SEL_LAT_AUTO: rd_word = lat_auto;
            SSO_SEL_LAT_DIFF: rd_word = lat_diff_q;
            default: rd_word = 16'h0000;
        endcase
    end

    // only the three documented resolution codes are accepted
    always_comb begin
        case (od_req.wdata)
            SSO_RES_1DEG: res_ok = 1'b1;
            SSO_RES_TENTH: res_ok = 1'b1;
            SSO_RES_HUNDREDTH: res_ok = 1'b1;
            default: res_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // dictionary access

    // settings writes, preset strobes and the answer
    always_comb begin
        long_op_d = long_op_q;
        lat_op_d = lat_op_q;
        long_preset_d = long_preset_q;
        lat_preset_d = lat_preset_q;
        long_diff_d = long_diff_q;
        lat_diff_d = lat_diff_q;
        res_d = res_q;
        long_pre_wr = 1'b0;
        lat_pre_wr = 1'b0;
        long_auto_wr = 1'b0;
        lat_auto_wr = 1'b0;
        rsp_d = '0;
        if (od_req.wr) begin
            rsp_d.ack = 1'b1;
            case (sel)
                SSO_SEL_RES: begin
                    if (res_ok) begin
                        res_d = od_req.wdata;
                    end else begin
                        rsp_d.err = 1'b1;
                    end
                end
                SSO_SEL_LONG_OP: begin
                    long_op_d = od_req.wdata[7:0];
                end
                SSO_SEL_LONG_PRE: begin
                    long_preset_d = od_req.wdata;
                    long_pre_wr = 1'b1;
                end
                SSO_SEL_LONG_AUTO: begin
                    long_auto_wr = 1'b1;
                end
                SSO_SEL_LONG_DIFF: begin
                    long_diff_d = od_req.wdata;
                end
                SSO_SEL_LAT_OP: begin
                    lat_op_d = od_req.wdata[7:0];
                end
                SSO_SEL_LAT_PRE: begin
                    lat_preset_d = od_req.wdata;
                    lat_pre_wr = 1'b1;
                end
                SSO_SEL_LAT_AUTO: begin
                    lat_auto_wr = 1'b1;
                end
                SSO_SEL_LAT_DIFF: begin
                    lat_diff_d = od_req.wdata;
                end
                default: begin
                    rsp_d.err = 1'b1;
                end
            endcase
        end else if (od_req.rd) begin
            rsp_d.ack = 1'b1;
            rsp_d.rdata = rd_word;
            rsp_d.err = (sel == SSO_SEL_NONE);
        end
    end

    // one-cycle marker of a new processed sample
    always_comb begin
        valid_d = raw_in.valid;
    end

    // settings and answer registers, frozen while ce is low
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            long_op_q <= SSO_OP_RST;
            lat_op_q <= SSO_OP_RST;
            long_preset_q <= SSO_PRESET_RST;
            lat_preset_q <= SSO_PRESET_RST;
            long_diff_q <= SSO_DIFF_RST;
            lat_diff_q <= SSO_DIFF_RST;
            res_q <= SSO_RES_RST;
            rsp_q <= '0;
            valid_q <= 1'b0;
        end else if (ce) begin
            long_op_q <= long_op_d;
            lat_op_q <= lat_op_d;
            long_preset_q <= long_preset_d;
            lat_preset_q <= lat_preset_d;
            long_diff_q <= long_diff_d;
            lat_diff_q <= lat_diff_d;
            res_q <= res_d;
            rsp_q <= rsp_d;
            valid_q <= valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign od_rsp = rsp_q;
    assign resolution = res_q;
    assign slope_out.valid = valid_q;
    assign slope_out.longitudinal = long_slope;
    assign slope_out.lateral = lat_slope;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_res_code: assert property (@(posedge clock) disable iff (!nrst)
        res_q == 16'h03E8 || res_q == 16'h0064 || res_q == 16'h000A)
        else $error("resolution holds an illegal code");

    a_lat_readonly: assert property (@(posedge clock) disable iff (!nrst)
        ce && od_req.wr && od_req.index == 16'h6020 |=> od_rsp.ack && od_rsp.err)
        else $error("write to lateral slope not refused");

    a_diff_hold: assert property (@(posedge clock) disable iff (!nrst)
        ce && !(od_req.wr && (sel == SSO_SEL_LONG_DIFF || sel == SSO_SEL_LAT_DIFF))
        |=> $stable(long_diff_q) && $stable(lat_diff_q))
        else $error("differential offset changed without a write");

    a_preset_store: assert property (@(posedge clock) disable iff (!nrst)
        ce && od_req.wr && od_req.index == 16'h6012 |=> long_preset_q == $past(od_req.wdata))
        else $error("longitudinal preset not stored");

    a_answer_once: assert property (@(posedge clock) disable iff (!nrst)
        ce && (od_req.wr || od_req.rd) |=> od_rsp.ack ##1 (!od_rsp.ack || $past(!ce || od_req.wr || od_req.rd)))
        else $error("answer not a single pulse");

    a_lat_read: assert property (@(posedge clock) disable iff (!nrst)
        ce && od_req.rd && !od_req.wr && od_req.index == 16'h6020 |=> od_rsp.rdata == $past(lat_slope))
        else $error("lateral slope read wrong");

    a_op_effect: assert property (@(posedge clock) disable iff (!nrst)
        ce && od_req.wr && od_req.index == 16'h6011 |=> long_op_q == $past(od_req.wdata[7:0]))
        else $error("operating parameter not applied");

    a_lat_op_store: assert property (@(posedge clock) disable iff (!nrst)
        ce && od_req.wr && od_req.index == 16'h6021 |=> lat_op_q == $past(od_req.wdata[7:0]))
        else $error("lateral operating parameter not stored");

    a_lat_preset_store: assert property (@(posedge clock) disable iff (!nrst)
        ce && od_req.wr && od_req.index == 16'h6022 |=> lat_preset_q == $past(od_req.wdata))
        else $error("lateral preset not stored");

    a_res_refused: assert property (@(posedge clock) disable iff (!nrst)
        ce && od_req.wr && od_req.index == 16'h6000 && od_req.wdata != 16'h03E8 && od_req.wdata != 16'h0064
        && od_req.wdata != 16'h000A |=> od_rsp.err && $stable(res_q))
        else $error("illegal resolution code not refused");

    a_sample_marker: assert property (@(posedge clock) disable iff (!nrst)
        ce |=> slope_out.valid == $past(raw_in.valid))
        else $error("processed sample marker wrong");

    a_frozen_state: assert property (@(posedge clock) disable iff (!nrst)
        !ce |=> $stable(long_op_q) && $stable(lat_op_q) && $stable(res_q)
        && $stable(od_rsp) && $stable(slope_out))
        else $error("state changed while clock enable low");

    a_unmapped_read: assert property (@(posedge clock) disable iff (!nrst)
        ce && od_req.rd && !od_req.wr && sel == SSO_SEL_NONE |=> od_rsp.ack && od_rsp.err && od_rsp.rdata == 16'h0000)
        else $error("unmapped read not refused");
endmodule
`default_nettype wire
